// [pkg/bcx_pkg.sv]
// Package for the branch and CPU control execution unit
package bcx_pkg;

    // Instruction lengths in bytes
    localparam logic [15:0] LEN_1 = 16'h0001;
    localparam logic [15:0] LEN_2 = 16'h0002;
    localparam logic [15:0] LEN_3 = 16'h0003;
    localparam logic [15:0] LEN_4 = 16'h0004;

    // Trap vector and stack figures
    localparam logic [15:0] TRAP_VEC_LO  = 16'h003c;
    localparam logic [15:0] TRAP_VEC_HI  = 16'h003d;
    localparam logic [15:0] TRAP_PC_BACK = 16'h0004;
    localparam logic [15:0] TRAP_SP_DROP = 16'h0004;

    // Program status word field positions
    localparam int PSW_CY_POS  = 0;
    localparam int PSW_RBS_LO  = 8;
    localparam int PSW_RSS_POS = 13;
    localparam int PSW_IE_POS  = 15;

    // Reset values
    localparam logic [15:0] PC_RST  = 16'h0000;
    localparam logic [15:0] PSW_RST = 16'h0000;
    localparam logic [15:0] SP_RST  = 16'h0000;

    // Avalon register offsets (byte addresses)
    localparam logic [5:0] REG_CMD    = 6'h00;
    localparam logic [5:0] REG_OPND   = 6'h04;
    localparam logic [5:0] REG_PC     = 6'h08;
    localparam logic [5:0] REG_PSW    = 6'h0c;
    localparam logic [5:0] REG_SP     = 6'h10;
    localparam logic [5:0] REG_CTX    = 6'h14;
    localparam logic [5:0] REG_CNT    = 6'h18;
    localparam logic [5:0] REG_PTR    = 6'h1c;
    localparam logic [5:0] REG_MODES  = 6'h20;
    localparam logic [5:0] REG_STATUS = 6'h24;
    localparam logic [5:0] REG_TRAPW  = 6'h28;
    localparam logic [5:0] REG_TRAPP  = 6'h2c;

    // Command codes written to REG_CMD bits 4:0
    typedef enum logic [4:0] {
        OP_BIT_ONE   = 5'h01,
        OP_BIT_ZERO  = 5'h02,
        OP_TEST_CLR  = 5'h03,
        OP_TEST_SET  = 5'h04,
        OP_DEC_REG   = 5'h05,
        OP_DEC_MEM   = 5'h06,
        OP_CTX_TRAP  = 5'h07,
        OP_CTX_RET   = 5'h08,
        OP_CTX_RETL  = 5'h09,
        OP_CMP_CY    = 5'h0a,
        OP_CMP_NCY   = 5'h0b,
        OP_CMP_ACC   = 5'h0c,
        OP_SEL_BANK  = 5'h0d,
        OP_SEL_ALT   = 5'h0e,
        OP_UNMASK    = 5'h0f,
        OP_MASK      = 5'h10,
        OP_WR_STBY   = 5'h11,
        OP_WR_WDOG   = 5'h12
    } bcx_op_t;

    // Bit source for the bit tests
    localparam logic [1:0] SRC_ACC = 2'h0;
    localparam logic [1:0] SRC_SFR = 2'h1;
    localparam logic [1:0] SRC_MEM = 2'h2;

    // Operand word written to REG_OPND
    typedef struct packed {
        logic [7:0] disp;     // Signed branch offset
        logic [7:0] data;     // Tested byte, counter, immediate or string byte
        logic [7:0] data2;    // Second string byte or accumulator
        logic [1:0] src;      // Bit source
        logic [2:0] bitsel;   // Bit number or bank number
        logic       opc_bad;  // Immediate op-code check failed
        logic [1:0] spare;
    } bcx_opnd_t;

    // Context bank words R5:R4 and R7:R6
    typedef struct packed {
        logic [15:0] r76;
        logic [15:0] r54;
    } bcx_ctx_t;

endpackage

// [logic/bcx_exec.sv]
// Execution unit for bit branches, loops, context switch and CPU control
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module bcx_exec
    import bcx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [7:0]       standby_control_reg,
    output logic [7:0]       watchdog_mode_reg,
    output logic             interrupt_enable_flag
);

    // State of the unit
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_ANS  = 3'b100
    } bcx_state_t;

    bcx_state_t  state;
    bcx_opnd_t   opnd;
    bcx_ctx_t    ctx;
    logic [4:0]  cmd;
    logic [15:0] pc;
    logic [15:0] program_status_word;
    logic [15:0] stack_pointer;
    logic [7:0]  count;
    logic [15:0] dst_ptr;
    logic [15:0] src_ptr;
    logic        ptr_down;
    logic [7:0]  result;
    logic        taken;
    logic        str_done;
    logic        trap_hit;
    logic [31:0] trap_words;
    logic [15:0] trap_pc_push;
    logic [15:0] trap_vec;

    // Sign extension of the branch offset
    function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [15:0] len,
                                               input logic [7:0] off);
        rel_target = base + len + {{8{off[7]}}, off};
    endfunction

    function automatic logic bit_of(input logic [7:0] b, input logic [2:0] n);
        bit_of = b[n];
    endfunction

    logic       tbit;
    logic [7:0] dec_val;
    logic [8:0] diff;
    logic [15:0] next_pc;
    logic [7:0]  next_result;
    logic        next_taken;
    logic        long_form;
    logic [15:0] one_len;

    assign tbit      = bit_of(opnd.data, opnd.bitsel);
    assign dec_val   = opnd.data - 8'h01;
    assign long_form = opnd.src != SRC_ACC;
    assign one_len   = (opnd.src == SRC_SFR) ? LEN_4 : LEN_3; // Memory bit-one form is short

    // Subtract used by the string compares; the borrow is the carry
    always_comb
    begin
        if (cmd == OP_CMP_ACC)
            diff = {1'b0, opnd.data} - {1'b0, opnd.data2};
        else
            diff = {1'b0, opnd.data} - {1'b0, opnd.data2};
    end

    // Branch decision and new bit value
    always_comb
    begin
        next_pc     = pc;
        next_result = opnd.data;
        next_taken  = 1'b0;
        unique case (cmd)
            OP_BIT_ONE:
            begin
                next_taken = tbit;
                next_pc = tbit ? rel_target(pc, one_len, opnd.disp) : pc + one_len;
            end
            OP_BIT_ZERO:
            begin
                next_taken = !tbit;
                next_pc = !tbit ? rel_target(pc, long_form ? LEN_4 : LEN_3, opnd.disp)
                                : pc + (long_form ? LEN_4 : LEN_3);
            end
            OP_TEST_CLR:
            begin
                next_taken = tbit;
                if (tbit)
                    next_result[opnd.bitsel] = 1'b0;
                next_pc = tbit ? rel_target(pc, long_form ? LEN_4 : LEN_3, opnd.disp)
                               : pc + (long_form ? LEN_4 : LEN_3);
            end
            OP_TEST_SET:
            begin
                next_taken = !tbit;
                if (!tbit)
                    next_result[opnd.bitsel] = 1'b1;
                next_pc = !tbit ? rel_target(pc, long_form ? LEN_4 : LEN_3, opnd.disp)
                                : pc + (long_form ? LEN_4 : LEN_3);
            end
            OP_DEC_REG:
            begin
                next_result = dec_val;
                next_taken  = dec_val != 8'h00;
                next_pc = next_taken ? rel_target(pc, LEN_2, opnd.disp) : pc + LEN_2;
            end
            OP_DEC_MEM:
            begin
                next_result = dec_val;
                next_taken  = dec_val != 8'h00;
                next_pc = next_taken ? rel_target(pc, LEN_3, opnd.disp) : pc + LEN_3;
            end
            default:
            begin
                next_pc = pc;
            end
        endcase
    end

    assign trap_pc_push = pc - TRAP_PC_BACK;
    assign trap_vec     = {TRAP_VEC_HI[7:0], TRAP_VEC_LO[7:0]};

    // Bus handshake: one wait cycle (two for command writes), answer in the next
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            state <= ST_IDLE;
        else
            unique case (state)
                ST_IDLE: if (avs_read || avs_write) state <= (avs_write && avs_address == REG_CMD)
                                                           ? ST_EXEC : ST_ANS;
                ST_EXEC: state <= ST_ANS;
                ST_ANS:  state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !(state != ST_ANS && (avs_read || avs_write) && avs_waitrequest
                                 && (state == ST_EXEC || !(avs_write && avs_address == REG_CMD)));
    end

    logic accept;
    assign accept = state == ST_IDLE && avs_write && avs_address != REG_CMD;

    // Operand and side registers written by software
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            opnd <= '0;
            ctx  <= '0;
            dst_ptr <= 16'h0000;
            src_ptr <= 16'h0000;
            ptr_down <= 1'b0;
        end
        else if (accept)
        begin
            unique case (avs_address)
                REG_OPND: opnd <= avs_writedata;
                REG_CTX:  ctx.r54 <= avs_writedata[15:0];
                REG_PTR:
                begin
                    dst_ptr  <= avs_writedata[15:0];
                    src_ptr  <= avs_writedata[31:16];
                end
                REG_STATUS: ptr_down <= avs_writedata[0];
                REG_CNT:  ctx.r76 <= avs_writedata[31:16];
                default:  ;
            endcase
        end
        else if (state == ST_EXEC)
        begin
            unique case (cmd)
                OP_CTX_TRAP:
                begin
                    ctx.r54 <= pc;
                    ctx.r76 <= program_status_word;
                end
                OP_CTX_RET, OP_CTX_RETL: ctx.r54 <= {opnd.data2, opnd.data};
                OP_CMP_CY, OP_CMP_NCY:
                begin
                    dst_ptr <= ptr_down ? dst_ptr - 16'h0001 : dst_ptr + 16'h0001;
                    src_ptr <= ptr_down ? src_ptr - 16'h0001 : src_ptr + 16'h0001;
                end
                OP_CMP_ACC: dst_ptr <= ptr_down ? dst_ptr - 16'h0001 : dst_ptr + 16'h0001;
                default: ;
            endcase
        end
    end

    // Latch the command at the wait cycle so execution sees it
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            cmd <= 5'h00;
        else if (state == ST_IDLE && avs_write && avs_address == REG_CMD)
            cmd <= avs_writedata[4:0];
    end

    // Program counter, status word, stack pointer
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            pc  <= PC_RST;
            program_status_word <= PSW_RST;
            stack_pointer <= SP_RST;
            result <= 8'h00;
            taken  <= 1'b0;
            trap_hit <= 1'b0;
            trap_words <= 32'h0000_0000;
        end
        else if (accept && avs_address == REG_PC)
            pc <= avs_writedata[15:0];
        else if (accept && avs_address == REG_PSW)
            program_status_word <= avs_writedata[15:0];
        else if (accept && avs_address == REG_SP)
            stack_pointer <= avs_writedata[15:0];
        else if (state == ST_EXEC)
        begin
            result <= next_result;
            taken  <= next_taken;
            pc     <= next_pc;
            trap_hit <= 1'b0;
            unique case (cmd)
                OP_CTX_TRAP:
                begin
                    pc <= ctx.r54;
                    program_status_word[PSW_RBS_LO +: 3] <= opnd.bitsel;
                    program_status_word[PSW_RSS_POS] <= 1'b0;
                    program_status_word[PSW_IE_POS]  <= 1'b0;
                end
                OP_CTX_RET, OP_CTX_RETL:
                begin
                    pc  <= ctx.r54;
                    program_status_word <= ctx.r76;
                end
                OP_CMP_CY, OP_CMP_NCY, OP_CMP_ACC:
                begin
                    program_status_word[PSW_CY_POS] <= diff[8];
                    result <= diff[7:0];
                end
                OP_SEL_BANK:
                begin
                    program_status_word[PSW_RSS_POS] <= 1'b0;
                    program_status_word[PSW_RBS_LO +: 3] <= opnd.bitsel;
                    pc <= pc + LEN_2;
                end
                OP_SEL_ALT:
                begin
                    program_status_word[PSW_RSS_POS] <= 1'b1;
                    program_status_word[PSW_RBS_LO +: 3] <= opnd.bitsel;
                    pc <= pc + LEN_2;
                end
                OP_UNMASK:
                begin
                    program_status_word[PSW_IE_POS] <= 1'b1;
                    pc <= pc + LEN_1;
                end
                OP_MASK:
                begin
                    program_status_word[PSW_IE_POS] <= 1'b0;
                    pc <= pc + LEN_1;
                end
                OP_WR_STBY, OP_WR_WDOG:
                begin
                    if (opnd.opc_bad)
                    begin
                        // Stack images: SP-1 status high, SP-2 low, SP-3/4 faulting PC less TRAP_PC_BACK
                        trap_words <= {program_status_word[15:8], program_status_word[7:0], trap_pc_push};
                        pc <= trap_vec;
                        stack_pointer <= stack_pointer - TRAP_SP_DROP;
                        program_status_word[PSW_IE_POS] <= 1'b0;
                        trap_hit <= 1'b1;
                    end
                    else
                        pc <= pc + LEN_4;
                end
                default: ;
            endcase
        end
    end

    // Protected mode registers; a bad op-code leaves them untouched
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            standby_control_reg <= 8'h00;
            watchdog_mode_reg   <= 8'h00;
        end
        else if (state == ST_EXEC && !opnd.opc_bad)
        begin
            if (cmd == OP_WR_STBY)
                standby_control_reg <= opnd.data;
            if (cmd == OP_WR_WDOG)
                watchdog_mode_reg <= opnd.data;
        end
    end

    // String count: one step per command, done flag for software looping
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            count    <= 8'h00;
            str_done <= 1'b0;
        end
        else if (accept && avs_address == REG_CNT)
        begin
            count    <= avs_writedata[7:0];
            str_done <= 1'b0;
        end
        else if (state == ST_EXEC && (cmd == OP_CMP_CY || cmd == OP_CMP_NCY || cmd == OP_CMP_ACC))
        begin
            count <= count - 8'h01;
            if (cmd == OP_CMP_CY)
                str_done <= count == 8'h01 || !diff[8];
            else
                str_done <= count == 8'h01 || diff[8];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            interrupt_enable_flag <= 1'b0;
        else
            interrupt_enable_flag <= program_status_word[PSW_IE_POS];
    end

    // Read mux; unmapped offsets answer zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && state == ST_IDLE)
        begin
            unique case (avs_address)
                REG_PC:     avs_readdata <= {16'h0000, pc};
                REG_PSW:    avs_readdata <= {16'h0000, program_status_word};
                REG_SP:     avs_readdata <= {16'h0000, stack_pointer};
                REG_CTX:    avs_readdata <= ctx;
                REG_CNT:    avs_readdata <= {24'h000000, count};
                REG_PTR:    avs_readdata <= {src_ptr, dst_ptr};
                REG_MODES:  avs_readdata <= {16'h0000, watchdog_mode_reg, standby_control_reg};
                REG_STATUS: avs_readdata <= {20'h00000, result, 1'b0, trap_hit, str_done, taken};
                REG_TRAPW:  avs_readdata <= trap_words;
                REG_TRAPP:  avs_readdata <= {16'h0000, stack_pointer};
                default:    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // bcx_exec

// [tb/bcx_exec_assertions.sv]
// Port checker for the branch and CPU control execution unit
`timescale 1ns/10ps
module bcx_exec_assertions
    import bcx_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  standby_control_reg,
    input wire logic [7:0]  watchdog_mode_reg,
    input wire logic        interrupt_enable_flag
);
    bcx_opnd_t  opnd_q;
    logic       cmd_ack;
    logic [4:0] op;

    assign cmd_ack = avs_write && !avs_waitrequest && (avs_address == REG_CMD);
    assign op      = avs_writedata[4:0];

    // Operand kept so that a later mode write can be judged against it
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            opnd_q <= '0;
        else if (avs_write && !avs_waitrequest && (avs_address == REG_OPND))
            opnd_q <= bcx_opnd_t'(avs_writedata);
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_CMD_LATENCY: assert property (
        avs_write && (avs_address == REG_CMD) && !$past(avs_write)
        |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
        else $error("Command write answered at the wrong cycle");
    AST_PLAIN_LATENCY: assert property (
        (avs_read || (avs_write && (avs_address != REG_CMD))) && !$past(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Register access answered at the wrong cycle");
    AST_ACK_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait request low for more than one cycle");
    AST_UNMAPPED_ZERO: assert property (
        avs_read && !avs_waitrequest && (avs_address > REG_TRAPP) |-> avs_readdata == 32'h0)
        else $error("Unmapped read returned data");
    AST_UNMASK_IE: assert property (
        cmd_ack && (op == OP_UNMASK) |-> ##[1:2] interrupt_enable_flag)
        else $error("Unmask left interrupts disabled");
    AST_MASK_IE: assert property (
        cmd_ack && (op == OP_MASK) |-> ##[1:2] !interrupt_enable_flag)
        else $error("Mask left interrupts enabled");
    AST_CTX_IE: assert property (
        cmd_ack && (op == OP_CTX_TRAP) |-> ##[1:2] !interrupt_enable_flag)
        else $error("Context switch left interrupts enabled");
    AST_STBY_LOAD: assert property (
        cmd_ack && (op == OP_WR_STBY) && !opnd_q.opc_bad
        |-> ##[1:2] standby_control_reg == opnd_q.data)
        else $error("Standby register not loaded");
    AST_WDOG_LOAD: assert property (
        cmd_ack && (op == OP_WR_WDOG) && !opnd_q.opc_bad
        |-> ##[1:2] watchdog_mode_reg == opnd_q.data)
        else $error("Watchdog mode register not loaded");
    AST_TRAP_IE: assert property (
        cmd_ack && ((op == OP_WR_STBY) || (op == OP_WR_WDOG)) && opnd_q.opc_bad
        |-> ##[1:2] !interrupt_enable_flag)
        else $error("Op-code trap left interrupts enabled");
endmodule // bcx_exec_assertions

bind bcx_exec bcx_exec_assertions i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .standby_control_reg(standby_control_reg),
    .watchdog_mode_reg(watchdog_mode_reg), .interrupt_enable_flag(interrupt_enable_flag)
);

// [tb/tb_branch_and_cpu_control_exec.sv]
// Self-checking bench for the branch and CPU control execution unit
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb_branch_and_cpu_control_exec
    import bcx_pkg::*;
;
    logic        core_clk;
    logic        rst_b;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  standby_control_reg;
    logic [7:0]  watchdog_mode_reg;
    logic        interrupt_enable_flag;
    int          n_errors;
    int          compares;
    logic [63:0] exp_q[$];

    bcx_exec i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .standby_control_reg(standby_control_reg),
        .watchdog_mode_reg(watchdog_mode_reg), .interrupt_enable_flag(interrupt_enable_flag)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        if (exp_q.size() != 0)
        begin
            n_errors++;
            $display("Error at %0t: reads left unanswered", $time);
        end
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Request held until the edge that samples wait request low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic run(input bcx_op_t op, input bcx_opnd_t o);
        bus(1'b1, REG_OPND, o);
        bus(1'b1, REG_CMD, {27'h0, op});
    endtask

    // Branch step from a random address; offset is signed
    task automatic step(input bcx_op_t op, input bcx_opnd_t o, input logic [15:0] len,
                        input logic tk, input logic [7:0] res);
        logic [15:0] pc;
        pc = 16'($urandom);
        bus(1'b1, REG_PC, {16'h0, pc});
        run(op, o);
        rd(REG_PC, {16'h0, pc + len + (tk ? {{8{o.disp[7]}}, o.disp} : 16'h0)},
           32'hffff);
        rd(REG_STATUS, {20'h0, res, 3'h0, tk}, 32'hff1);
    endtask

    // Oldest note compared whenever read data is handed over
    always @(posedge core_clk)
    begin
        logic [63:0] note;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            if (exp_q.size() == 0)
            begin
                n_errors++;
                $display("Error at %0t: read with no expected value", $time);
            end
            else
            begin
                note = exp_q.pop_front();
                `CHK(avs_readdata & note[63:32], note[31:0])
            end
        end
    end

    initial
    begin
        #(4 * 40000);
        n_errors++;
        $display("Error at %0t: timeout", $time);
        wrap_up();
    end

    initial
    begin
        logic [15:0] pc;
        logic [15:0] program_status_word;
        logic [15:0] sp;
        logic [7:0]  d;
        logic [7:0]  res;
        logic        tk;
        logic        cy;
        bcx_opnd_t   o;
        bcx_op_t     op;
        logic [7:0]  sb;
        logic [7:0]  wd;
        logic [31:0] pv;
        void'($urandom(74473));
        rst_b = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sb = 8'h00;
        wd = 8'h00;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(6'h30, 32'h0, 32'hffffffff);
        for (int i = 0; i < 36; i++)
        begin
            op = bcx_op_t'(5'h01 + 5'(i % 4));
            o = bcx_opnd_t'($urandom);
            o.src = 2'(i / 4 % 3);
            d = o.data;
            tk = (op == OP_BIT_ONE || op == OP_TEST_CLR) ? d[o.bitsel] : !d[o.bitsel];
            res = d;
            if (tk && op == OP_TEST_CLR)
                res[o.bitsel] = 1'b0;
            if (tk && op == OP_TEST_SET)
                res[o.bitsel] = 1'b1;
            step(op, o, (o.src == SRC_ACC || (op == OP_BIT_ONE && o.src == SRC_MEM)) ? LEN_3
                 : LEN_4, tk, res);
        end
        for (int i = 0; i < 6; i++)
        begin
            o = bcx_opnd_t'($urandom);
            o.data = (i < 2) ? 8'h01 : ((i < 4) ? 8'h00 : o.data);
            d = o.data - 8'h01;
            step((i % 2) ? OP_DEC_MEM : OP_DEC_REG, o, (i % 2) ? LEN_3 : LEN_2,
                 d != 8'h0, d);
        end
        for (int i = 0; i < 2; i++)
        begin
            pc = 16'($urandom);
            program_status_word = 16'($urandom) | 16'ha000;
            sp = 16'($urandom);
            o = bcx_opnd_t'($urandom);
            o.bitsel = 3'(i + 5);
            bus(1'b1, REG_PC, {16'h0, pc});
            bus(1'b1, REG_PSW, {16'h0, program_status_word});
            bus(1'b1, REG_CTX, {16'h0, sp});
            run(OP_CTX_TRAP, o);
            rd(REG_PC, {16'h0, sp}, 32'hffff);
            rd(REG_CTX, {program_status_word, pc}, 32'hffffffff);
            rd(REG_PSW, {16'h0, (program_status_word & 16'h58ff) | {5'h0, o.bitsel, 8'h0}}, 32'hffff);
            run(i ? OP_CTX_RETL : OP_CTX_RET, o);
            rd(REG_PC, {16'h0, pc}, 32'hffff);
            rd(REG_PSW, {16'h0, program_status_word}, 32'hffff);
            rd(REG_CTX, {program_status_word, o.data2, o.data}, 32'hffffffff);
        end
        for (int i = 0; i < 9; i++)
        begin
            op = bcx_op_t'(5'h0a + 5'(i % 3));
            o = bcx_opnd_t'($urandom);
            o.opc_bad = 1'b0;
            d = (i < 3) ? 8'h01 : 8'($urandom_range(255, 2));
            pv = $urandom;
            bus(1'b1, REG_PTR, pv);
            bus(1'b1, REG_STATUS, {31'h0, i[0]});
            bus(1'b1, REG_CNT, {24'h0, d});
            run(op, o);
            rd(REG_PTR, {(op == OP_CMP_ACC) ? pv[31:16] : pv[31:16] + (i[0] ? 16'hffff : 16'h1),
                         pv[15:0] + (i[0] ? 16'hffff : 16'h1)}, 32'hffffffff);
            cy = o.data < o.data2;
            d = d - 8'h01;
            tk = (d == 8'h0) || ((op == OP_CMP_CY) ? !cy : cy);
            rd(REG_CNT, {24'h0, d}, 32'hff);
            rd(REG_PSW, {31'h0, cy}, 32'h1);
            rd(REG_STATUS, {30'h0, tk, 1'b0}, 32'h2);
        end
        for (int i = 0; i < 16; i++)
        begin
            o = '0;
            o.bitsel = 3'(i);
            run((i < 8) ? OP_SEL_BANK : OP_SEL_ALT, o);
            rd(REG_PSW, {18'h0, (i >= 8), 2'h0, 3'(i), 8'h0}, 32'h2700);
        end
        bus(1'b1, REG_PC, 32'h0);
        run(OP_UNMASK, '0);
        rd(REG_PSW, 32'h8000, 32'h8000);
        rd(REG_PC, 32'h1, 32'hffff);
        run(OP_MASK, '0);
        rd(REG_PSW, 32'h0, 32'h8000);
        rd(REG_PC, 32'h2, 32'hffff);
        for (int i = 0; i < 4; i++)
        begin
            o = bcx_opnd_t'($urandom);
            o.opc_bad = i[1];
            pc = 16'($urandom);
            program_status_word = 16'($urandom) | 16'h8000;
            sp = 16'($urandom);
            bus(1'b1, REG_PC, {16'h0, pc});
            bus(1'b1, REG_PSW, {16'h0, program_status_word});
            bus(1'b1, REG_SP, {16'h0, sp});
            run(i[0] ? OP_WR_WDOG : OP_WR_STBY, o);
            rd(REG_STATUS, {29'h0, i[1], 2'h0}, 32'h4);
            if (i[1])
            begin
                rd(REG_PC, {16'h0, TRAP_VEC_HI[7:0], TRAP_VEC_LO[7:0]}, 32'hffff);
                rd(REG_SP, {16'h0, sp - TRAP_SP_DROP}, 32'hffff);
                rd(REG_PSW, 32'h0, 32'h8000);
                rd(REG_TRAPW, {program_status_word, pc - TRAP_PC_BACK}, 32'hffffffff);
            end
            else
            begin
                rd(REG_PC, {16'h0, pc + LEN_4}, 32'hffff);
                if (i[0])
                    wd = o.data;
                else
                    sb = o.data;
            end
            rd(REG_MODES, {16'h0, wd, sb}, 32'hffff);
        end
        repeat (4) @(posedge core_clk);
        wrap_up();
    end
endmodule // tb_branch_and_cpu_control_exec
